// >>> hw/cifl_pkg.sv
package cifl_pkg;

	// ==========================================================
	// Widths and counts
	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	localparam int PRIO_W = 3;
	localparam int ARCH_REG_COUNT = 13;
	localparam int BANK_COUNT = 2;
	localparam int TRAP_W = 6;

	// ==========================================================
	// Flag values and limits
	localparam logic MASK_BLOCK = 1'b0;
	localparam logic MASK_OPEN = 1'b1;
	localparam logic STACK_SEL_IRQ = 1'b0;
	localparam logic STACK_SEL_TASK = 1'b1;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
	localparam logic [TRAP_W-1:0] TRAP_LOW_LAST = 6'h1F;
	localparam logic RESERVED_READ = 1'b0;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

	// ==========================================================
	// Bank register selector
	typedef enum logic [2:0] {
		CIFL_SEL_DATA0,
		CIFL_SEL_DATA1,
		CIFL_SEL_DATA2,
		CIFL_SEL_DATA3,
		CIFL_SEL_ADDR0,
		CIFL_SEL_ADDR1,
		CIFL_SEL_FRAME
	} cifl_bank_sel_t;

	localparam int BANK_REGS = 7;

	// Flag word as software sees it
	typedef struct packed {
		logic [PRIO_W-1:0] core_priority_level;
		logic reserved;
		logic stack_sel;
		logic mask_enable;
	} cifl_flags_t;

	// Interrupt request from the request logic
	typedef struct packed {
		logic valid;
		logic [PRIO_W-1:0] prio;
	} cifl_req_t;

endpackage

// >>> hw/cifl_bank_file.sv
`timescale 1ns/1ps

// Two banked copies of data, address and frame base registers
module cifl_bank_file (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bank_sel_i,
	input wire logic wr_en_i,
	input wire cifl_pkg::cifl_bank_sel_t wr_sel_i,
	input wire logic [cifl_pkg::DATA_W-1:0] wr_data_i,
	input wire cifl_pkg::cifl_bank_sel_t rd_sel_i,
	output logic [cifl_pkg::DATA_W-1:0] rd_data_o
);
	logic [cifl_pkg::DATA_W-1:0] bank_mem [cifl_pkg::BANK_COUNT]
		[cifl_pkg::BANK_REGS];

	// ==========================================================
	// Storage, one generate entry per bank
	genvar b;
	generate
		for (b = 0; b < cifl_pkg::BANK_COUNT; b++) begin : g_bank
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					for (int r = 0; r < cifl_pkg::BANK_REGS; r++) begin
						bank_mem[b][r] <= cifl_pkg::REG_RESET;
					end
				end else if (wr_en_i && (int'(bank_sel_i) == b)) begin
					bank_mem[b][wr_sel_i] <= wr_data_i;
				end
			end
		end
	endgenerate

	// Registered read so the data output comes from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= cifl_pkg::REG_RESET;
		end else begin
			rd_data_o <= bank_mem[bank_sel_i][rd_sel_i];
		end
	end

endmodule // cifl_bank_file

// >>> hw/cifl_core_flags.sv
`timescale 1ns/1ps

// Summary of operation
// - Thirteen registers; four data, two address, frame base form one bank.
// - Two full bank copies exist, one selected at a time.
// - Mask enable 0 refuses maskable requests; 1 allows them.
// - Any interrupt acknowledge clears mask enable to 0.
// - Stack select 0 picks irq stack pointer, 1 picks task pointer.
// - Hardware acknowledge or trap vector 0..31 clears stack select.
// - Core priority level is three bits, levels 0 through 7.
// - Request admitted only if priority strictly above core level.
// - Reserved flag bit written 0; reads must not rely on it.
module cifl_core_flags (
	input wire logic clk_i,
	input wire logic rst_i,
	// Pending request from request logic
	input wire cifl_pkg::cifl_req_t req_i,
	input wire logic req_nonmaskable_i,
	// Sequencer events
	input wire logic ack_hw_i,
	input wire logic ack_any_i,
	input wire logic trap_exec_i,
	input wire logic [cifl_pkg::TRAP_W-1:0] trap_num_i,
	// Software flag write
	input wire logic flags_wr_i,
	input wire cifl_pkg::cifl_flags_t flags_wdata_i,
	// Bank select and register access
	input wire logic bank_sel_i,
	input wire logic reg_wr_i,
	input wire cifl_pkg::cifl_bank_sel_t reg_wr_sel_i,
	input wire logic [cifl_pkg::DATA_W-1:0] reg_wdata_i,
	input wire cifl_pkg::cifl_bank_sel_t reg_rd_sel_i,
	// Stack pointer writes
	input wire logic sp_wr_i,
	input wire logic [cifl_pkg::ADDR_W-1:0] sp_wdata_i,
	output logic [cifl_pkg::DATA_W-1:0] reg_rdata_o,
	output cifl_pkg::cifl_flags_t flags_o,
	output logic [cifl_pkg::ADDR_W-1:0] active_sp_o,
	output logic admit_o
);
	logic mask_enable;
	logic stack_sel;
	logic [cifl_pkg::PRIO_W-1:0] core_priority_level;
	logic [cifl_pkg::ADDR_W-1:0] irq_stack_pointer;
	logic [cifl_pkg::ADDR_W-1:0] task_stack_pointer;
	logic low_trap;
	logic prio_above;

	// ==========================================================
	// Admission
	assign prio_above = req_i.prio > core_priority_level;
	// Non-maskable requests bypass the mask but not the level test
	assign admit_o = req_i.valid && prio_above &&
		(mask_enable == cifl_pkg::MASK_OPEN || req_nonmaskable_i);

	assign low_trap = trap_exec_i &&
		(trap_num_i <= cifl_pkg::TRAP_LOW_LAST);

	// ==========================================================
	// Mask enable flag; acknowledge wins over a same-cycle write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_enable <= cifl_pkg::MASK_BLOCK;
		end else if (ack_any_i) begin
			mask_enable <= cifl_pkg::MASK_BLOCK;
		end else if (flags_wr_i) begin
			mask_enable <= flags_wdata_i.mask_enable;
		end
	end

	// Stack select flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_sel <= cifl_pkg::STACK_SEL_IRQ;
		end else if (ack_hw_i || low_trap) begin
			stack_sel <= cifl_pkg::STACK_SEL_IRQ;
		end else if (flags_wr_i) begin
			stack_sel <= flags_wdata_i.stack_sel;
		end
	end

	// Priority level, full 3-bit range writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_priority_level <= cifl_pkg::PRIO_RESET;
		end else if (flags_wr_i) begin
			core_priority_level <= flags_wdata_i.core_priority_level;
		end
	end

	// ==========================================================
	// Stack pointers; write goes to the one currently selected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stack_pointer <= cifl_pkg::REG_RESET;
			task_stack_pointer <= cifl_pkg::REG_RESET;
		end else if (sp_wr_i) begin
			if (stack_sel == cifl_pkg::STACK_SEL_TASK) begin
				task_stack_pointer <= sp_wdata_i;
			end else begin
				irq_stack_pointer <= sp_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_sp_o <= cifl_pkg::REG_RESET;
		end else begin
			active_sp_o <= (stack_sel == cifl_pkg::STACK_SEL_TASK) ?
				task_stack_pointer : irq_stack_pointer;
		end
	end

	// Reserved bit always reads a fixed value
	always_comb begin
		flags_o.mask_enable = mask_enable;
		flags_o.stack_sel = stack_sel;
		flags_o.reserved = cifl_pkg::RESERVED_READ;
		flags_o.core_priority_level = core_priority_level;
	end

	// ==========================================================
	// Banked general registers
	cifl_bank_file u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bank_sel_i(bank_sel_i),
		.wr_en_i(reg_wr_i),
		.wr_sel_i(reg_wr_sel_i),
		.wr_data_i(reg_wdata_i),
		.rd_sel_i(reg_rd_sel_i),
		.rd_data_o(reg_rdata_o)
	);

	// ==========================================================
	// Checks
	property p_mask_blocks;
		@(posedge clk_i) disable iff (rst_i)
		(mask_enable == cifl_pkg::MASK_BLOCK && !req_nonmaskable_i)
			|-> !admit_o;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("maskable admit while mask closed");

	property p_ack_clears_mask;
		@(posedge clk_i) disable iff (rst_i)
		ack_any_i |=> mask_enable == cifl_pkg::MASK_BLOCK;
	endproperty
	a_ack_clears_mask: assert property (p_ack_clears_mask)
		else $error("mask not cleared after ack");

	property p_sp_follows_sel;
		@(posedge clk_i) disable iff (rst_i)
		##1 active_sp_o == ($past(stack_sel) ? $past(task_stack_pointer)
			: $past(irq_stack_pointer));
	endproperty
	a_sp_follows_sel: assert property (p_sp_follows_sel)
		else $error("active stack pointer wrong");

	property p_stack_clear;
		@(posedge clk_i) disable iff (rst_i)
		(ack_hw_i || (trap_exec_i &&
			trap_num_i <= cifl_pkg::TRAP_LOW_LAST))
			|=> stack_sel == cifl_pkg::STACK_SEL_IRQ;
	endproperty
	a_stack_clear: assert property (p_stack_clear)
		else $error("stack select not cleared");

	property p_high_trap_keeps;
		@(posedge clk_i) disable iff (rst_i)
		(trap_exec_i && trap_num_i > cifl_pkg::TRAP_LOW_LAST &&
			!ack_hw_i && !flags_wr_i)
			|=> $stable(stack_sel);
	endproperty
	a_high_trap_keeps: assert property (p_high_trap_keeps)
		else $error("high trap changed stack select");

	property p_prio_write;
		@(posedge clk_i) disable iff (rst_i)
		flags_wr_i |=> core_priority_level ==
			$past(flags_wdata_i.core_priority_level);
	endproperty
	a_prio_write: assert property (p_prio_write)
		else $error("priority level write lost");

	property p_equal_prio_held;
		@(posedge clk_i) disable iff (rst_i)
		(req_i.prio <= core_priority_level) |-> !admit_o;
	endproperty
	a_equal_prio_held: assert property (p_equal_prio_held)
		else $error("low or equal priority admitted");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (rst_i)
		flags_wr_i |=> flags_o.reserved == cifl_pkg::RESERVED_READ;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit not zero");

	property p_admit_cause;
		@(posedge clk_i) disable iff (rst_i)
		(req_i.valid && req_i.prio > core_priority_level &&
			mask_enable == cifl_pkg::MASK_OPEN) |-> admit_o;
	endproperty
	a_admit_cause: assert property (p_admit_cause)
		else $error("qualified request not admitted");

	property p_admit_needs_valid;
		@(posedge clk_i) disable iff (rst_i)
		!req_i.valid |-> !admit_o;
	endproperty
	a_admit_needs_valid: assert property (p_admit_needs_valid)
		else $error("admit without a pending request");

	// Software write only lands when no acknowledge competes
	property p_mask_write;
		@(posedge clk_i) disable iff (rst_i)
		(flags_wr_i && !ack_any_i) |=> mask_enable ==
			$past(flags_wdata_i.mask_enable);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask enable write lost");

endmodule // cifl_core_flags

// >>> verification/cifl_seq_model.sv
`timescale 1ns/1ps

// Stand-in for the request logic and sequencer; events are 1-cycle pulses
module cifl_seq_model (
	input wire logic clk_i,
	output cifl_pkg::cifl_req_t req_o,
	output logic nmi_o,
	output logic ack_hw_o,
	output logic ack_any_o,
	output logic trap_o,
	output logic [cifl_pkg::TRAP_W-1:0] num_o
);
	initial begin
		req_o = '0;
		nmi_o = 1'b0;
		ack_hw_o = 1'b0;
		ack_any_o = 1'b0;
		trap_o = 1'b0;
		num_o = '0;
	end
	task automatic request(input logic [3:0] r, input logic nm);
		req_o = r;
		nmi_o = nm;
	endtask
	// A hardware ack always comes with the any-ack strobe
	task automatic ack(input logic hw);
		@(posedge clk_i) #1;
		ack_hw_o = hw;
		ack_any_o = 1'b1;
		@(posedge clk_i) #1;
		ack_hw_o = 1'b0;
		ack_any_o = 1'b0;
	endtask
	// Vector inverted once released, so a stale value is never trusted
	task automatic trap(input logic [cifl_pkg::TRAP_W-1:0] n);
		@(posedge clk_i) #1;
		trap_o = 1'b1;
		num_o = n;
		@(posedge clk_i) #1;
		trap_o = 1'b0;
		num_o = ~n;
	endtask
endmodule // cifl_seq_model

// >>> verification/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	cifl_pkg::cifl_req_t req;
	logic nmi, ack_hw, ack_any, trap;
	logic [cifl_pkg::TRAP_W-1:0] tnum;
	logic fwr = 1'b0;
	logic [5:0] fdat = '0;
	logic bsel = 1'b0;
	logic rwr = 1'b0;
	cifl_pkg::cifl_bank_sel_t wsel = cifl_pkg::CIFL_SEL_DATA0;
	cifl_pkg::cifl_bank_sel_t rsel = cifl_pkg::CIFL_SEL_DATA0;
	logic [15:0] wdat = '0;
	logic spwr = 1'b0;
	logic [15:0] spdat = '0;
	logic [15:0] rdat, asp;
	cifl_pkg::cifl_flags_t flags;
	logic admit;
	int errors = 0;
	int cmp_count = 0;
	always #5 clk_i = ~clk_i;
	cifl_seq_model u_seq (.clk_i(clk_i), .req_o(req), .nmi_o(nmi),
		.ack_hw_o(ack_hw), .ack_any_o(ack_any), .trap_o(trap), .num_o(tnum));
	cifl_core_flags u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.req_nonmaskable_i(nmi), .ack_hw_i(ack_hw), .ack_any_i(ack_any),
		.trap_exec_i(trap), .trap_num_i(tnum), .flags_wr_i(fwr),
		.flags_wdata_i(fdat), .bank_sel_i(bsel), .reg_wr_i(rwr),
		.reg_wr_sel_i(wsel), .reg_wdata_i(wdat), .reg_rd_sel_i(rsel),
		.sp_wr_i(spwr), .sp_wdata_i(spdat), .reg_rdata_o(rdat),
		.flags_o(flags), .active_sp_o(asp), .admit_o(admit));
	// ==========================================================
	// Helpers
	task automatic chk(input string w, input logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic step();
		@(posedge clk_i) #1;
	endtask
	// Reserved bit left out of compares: it always reads a fixed 0
	task automatic cf(input logic [2:0] l, input logic s, input logic m);
		chk("flags", {11'h000, l, s, m}, {11'h000,
			flags.core_priority_level, flags.stack_sel, flags.mask_enable});
	endtask
	task automatic wf(input logic [2:0] l, input logic s, input logic m);
		step();
		fwr = 1'b1;
		fdat = {l, 1'b0, s, m};
		step();
		fwr = 1'b0;
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rst_i = 1'b1;
		step();
		u_seq.request(4'hF, 1'b0);
		repeat (15) step();
		rst_i = 1'b0;
		cf(3'h0, 1'b0, 1'b0);
		chk("admit_rst", 16'h0000, 16'(admit));
		chk("rdata_rst", 16'h0000, rdat);
		chk("sp_rst", 16'h0000, asp);
	endtask
	task automatic t_admit();
		for (int m = 0; m < 2; m++) begin
			for (int l = 0; l < 8; l++) begin
				wf(l[2:0], 1'b0, m[0]);
				cf(l[2:0], 1'b0, m[0]);
				for (int p = 0; p < 8; p++) begin
					u_seq.request({1'b1, p[2:0]}, 1'b0);
					step();
					chk("admit", 16'(m == 1 && p > l), 16'(admit));
					u_seq.request({1'b1, p[2:0]}, 1'b1);
					step();
					chk("admit_nm", 16'(p > l), 16'(admit));
				end
			end
		end
		u_seq.request(4'h0, 1'b0);
	endtask
	task automatic t_ack();
		logic [5:0] nums [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
		wf(3'h3, 1'b1, 1'b1);
		u_seq.ack(1'b0);
		cf(3'h3, 1'b1, 1'b0);
		wf(3'h3, 1'b1, 1'b1);
		u_seq.ack(1'b1);
		cf(3'h3, 1'b0, 1'b0);
		fork
			u_seq.ack(1'b1);
			wf(3'h5, 1'b1, 1'b1);
		join
		cf(3'h5, 1'b0, 1'b0);
		foreach (nums[i]) begin
			wf(3'h1, 1'b1, 1'b0);
			u_seq.trap(nums[i]);
			chk("trap_sel", 16'(nums[i] > 31), 16'(flags.stack_sel));
		end
	endtask
	task automatic t_bank();
		for (int b = 0; b < 2; b++) begin
			for (int r = 0; r < cifl_pkg::BANK_REGS; r++) begin
				step();
				bsel = b[0];
				rwr = 1'b1;
				wsel = cifl_pkg::cifl_bank_sel_t'(r);
				wdat = 16'h5A00 ^ 16'(b * 16 + r);
			end
			step();
			rwr = 1'b0;
		end
		for (int b = 0; b < 2; b++) begin
			for (int r = 0; r < cifl_pkg::BANK_REGS; r++) begin
				bsel = b[0];
				rsel = cifl_pkg::cifl_bank_sel_t'(r);
				step();
				chk("bank_reg", 16'h5A00 ^ 16'(b * 16 + r), rdat);
			end
		end
	endtask
	task automatic t_sp(input logic s, input logic [15:0] v);
		wf(3'h0, s, 1'b0);
		spwr = 1'b1;
		spdat = v;
		step();
		spwr = 1'b0;
		repeat (2) step();
		chk("active_sp", v, asp);
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("[ERR] run_time expected done seen timeout");
		final_report();
	end
	initial begin
		t_reset();
		t_admit();
		t_ack();
		t_bank();
		t_sp(1'b0, 16'h1234);
		t_sp(1'b1, 16'h5678);
		wf(3'h0, 1'b0, 1'b0);
		repeat (2) step();
		chk("irq_sp_kept", 16'h1234, asp);
		t_reset();
		final_report();
	end
endmodule // testbench
